//--- design/watchdog_timeout_control.sv
/*
 * Watchdog timer with AXI4-Lite register access, timeout reset request,
 * high-priority timeout interrupt and a maskable event interrupt.
 * Assumes clk_sys at 10 MHz and a free-running 32.768 kHz reference pin.
 */
`timescale 1ns/1ns
module watchdog_timeout_control
    import wdt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic lf_clk,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wdt_irq_q,
    output logic sys_reset_q,
    output logic irq_q
);
    // ==========================================================
    // Declarations
    logic aw_held_q;
    logic w_held_q;
    logic [3:0] waddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic wr_go;
    logic ctrl_wr;
    logic apply;
    logic [3:0] sel_q;
    logic irq_mode_q;
    logic timeout_flag_q;
    logic enable_q;
    logic unlock_q;
    logic [COUNT_W-1:0] count_q;
    logic tick;
    logic expire;
    logic immediate;
    logic to_reset;
    logic refresh;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] mask_q;
    logic [7:0] ctrl_rd;

    // Last count of a period for a select code
    function automatic logic [COUNT_W-1:0] terminal(input logic [3:0] sel);
        logic [COUNT_W:0] n;
        n = (17'h1 << BASE_SHIFT) << sel[2:0];
        return COUNT_W'(n - 17'h1);
    endfunction

    function automatic logic [3:0] word_of(input logic [31:0] addr);
        return {addr[3:2], 2'b00};
    endfunction

    lf_tick lf_tick_inst
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .lf_clk(lf_clk),
        .tick_q(tick)
    );

    // ==========================================================
    // AXI4-Lite write channel
    assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign ctrl_wr = wr_go & (waddr_q == OFF_CONTROL) & wstrb0_q;
    assign apply = ctrl_wr & unlock_q;

    // Address and data captured in either order
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_held_q <= 1'b1;
                waddr_q <= word_of(s_axi_awaddr);
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_wready <= 1'b1;
            if (wr_go)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (waddr_q == OFF_CONTROL || waddr_q == OFF_IRQ_STATUS ||
                            waddr_q == OFF_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ==========================================================
    // AXI4-Lite read channel
    assign ctrl_rd = {sel_q, irq_mode_q, timeout_flag_q, enable_q, unlock_q};

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (word_of(s_axi_araddr))
                OFF_CONTROL: s_axi_rdata <= {24'h0, ctrl_rd};
                OFF_IRQ_STATUS: s_axi_rdata <= {24'h0, status_q};
                OFF_IRQ_MASK: s_axi_rdata <= {24'h0, mask_q};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Control register
    // refresh restarts count
    assign refresh = apply & wdata_q[BIT_ENABLE];
    assign immediate = enable_q & (sel_q == SEL_IMMEDIATE);
    assign expire = enable_q & tick & (sel_q <= SEL_LONGEST) & ~refresh &
                    (count_q == terminal(sel_q));
    assign to_reset = immediate | (expire & ~irq_mode_q);
    // Unlock arms on a control write with the unlock bit while unarmed, lapses on any other write
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            unlock_q <= CONTROL_RESET[BIT_UNLOCK];
        else if (wr_go)
            unlock_q <= ctrl_wr & ~unlock_q & wdata_q[BIT_UNLOCK];
    end
    // Select, mode and enable fields
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sel_q <= CONTROL_RESET[SEL_MSB:SEL_LSB];
            irq_mode_q <= CONTROL_RESET[BIT_IRQ_MODE];
            enable_q <= CONTROL_RESET[BIT_ENABLE];
        end
        else if (apply)
        begin
            sel_q <= wdata_q[SEL_MSB:SEL_LSB];
            irq_mode_q <= wdata_q[BIT_IRQ_MODE];
            enable_q <= wdata_q[BIT_ENABLE];
        end
        else if (to_reset)
            enable_q <= 1'b0;  // Watchdog reset drops the enable
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            timeout_flag_q <= CONTROL_RESET[BIT_FLAG];
        else if (expire || immediate)
            timeout_flag_q <= 1'b1;
        else if (apply && !wdata_q[BIT_FLAG])
            timeout_flag_q <= 1'b0;
    end
    // ==========================================================
    // Timeout counter
    // count reference ticks
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            count_q <= '0;
        else if (!enable_q || refresh || expire)
            count_q <= '0;
        else if (tick)
            count_q <= count_q + 16'h1;
    end

    // ==========================================================
    // Reset request and high-priority interrupt
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sys_reset_q <= 1'b0;
            wdt_irq_q <= 1'b0;
        end
        else
        begin
            sys_reset_q <= to_reset;
            if (expire && irq_mode_q)
                wdt_irq_q <= 1'b1;
            else if (apply && !wdata_q[BIT_FLAG])
                wdt_irq_q <= 1'b0;
        end
    end
    // ==========================================================
    // Event status, mask and level interrupt
    always_comb
    begin
        status_d = status_q;
        if (wr_go && waddr_q == OFF_IRQ_STATUS && wstrb0_q)
            status_d = status_q & ~wdata_q[7:0];
        if (expire || immediate)
            status_d[BIT_EV_TIMEOUT] = 1'b1;  // Set beats clear
    end
    // Status and mask registers, registered interrupt level
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            status_q <= 8'h0;
            mask_q <= 8'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            if (wr_go && waddr_q == OFF_IRQ_MASK && wstrb0_q)
                mask_q <= wdata_q[7:0];
            irq_q <= |(status_d & mask_q);
        end
    end
endmodule

//--- design/wdt_pkg.sv
/*
 * Constants for the watchdog timeout block: register offsets, field
 * positions, reset values and timing figures.
 * Assumes a 32-bit AXI4-Lite register bus and a 32.768 kHz reference pin.
 */
package wdt_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h8;
    localparam logic [7:0] CONTROL_RESET = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Control field positions
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 4;
    localparam int BIT_IRQ_MODE = 3;
    localparam int BIT_FLAG = 2;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_UNLOCK = 0;
    // Interrupt status bit
    localparam int BIT_EV_TIMEOUT = 0;
    // ==========================================================
    // Timing
    localparam int LF_CLOCK_HZ = 32768;
    localparam int BASE_SHIFT = 9;
    localparam logic [3:0] SEL_LONGEST = 4'h7;
    localparam logic [3:0] SEL_IMMEDIATE = 4'h8;
    localparam int COUNT_W = 16;
endpackage

//--- design/lf_tick.sv
/*
 * Turns the low-frequency reference pin into a one-cycle tick on clk_sys.
 * Assumes the reference is far slower than clk_sys.
 */
`timescale 1ns/1ns
module lf_tick
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic lf_clk,
    output logic tick_q
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // Two-stage synchroniser, then rising edge detect
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            sync1_q <= lf_clk;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            tick_q <= sync2_q & ~prev_q;
        end
    end
endmodule

//--- verification/watchdog_timeout_control_chk.sv
/*
 * Port assertions for the watchdog block: bus answers, the one-cycle reset request pulse and the interrupt rise.
 * Assumes one clock, clk_sys, and the synchronous active-low reset rst_b.
 */
`timescale 1ns/1ns
module watchdog_timeout_control_chk
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wdt_irq_q,
    input wire logic sys_reset_q
);
    // ==========================================================
    // Clocking and bus steps
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ==========================================================
    // Assertions
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after take");
    a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after take");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    a_read_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_reset_pulse: assert property (sys_reset_q |=> !sys_reset_q)
        else $error("reset request longer than one cycle");
    a_irq_no_reset: assert property ($rose(wdt_irq_q) |-> !sys_reset_q && !$past(sys_reset_q))
        else $error("interrupt raised together with reset");
endmodule
bind watchdog_timeout_control watchdog_timeout_control_chk watchdog_timeout_control_chk_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wdt_irq_q(wdt_irq_q), .sys_reset_q(sys_reset_q));

//--- verification/watchdog_timeout_control_bench.sv
/*
 * Self-checking bench for the watchdog block over its register bus.
 * Assumes the reference pin toggles every 400 ns, so one tick is 8 clk_sys cycles.
 */
`timescale 1ns/1ns
module watchdog_timeout_control_bench;
    import wdt_pkg::*;
    logic clk_sys, rst_b, lf_clk;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, wdt_irq_q, sys_reset_q, irq_q;
    logic [1:0] bresp, rresp;
    int n_errors, checked;
    int n_rst = 0;
    watchdog_timeout_control watchdog_timeout_control_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .lf_clk(lf_clk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wdt_irq_q(wdt_irq_q), .sys_reset_q(sys_reset_q), .irq_q(irq_q));
    // ==========================================================
    // Clocks and reset request counter
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial
    begin
        lf_clk = 1'b0;
        #17;
        forever #400 lf_clk = ~lf_clk;
    end
    always @(posedge clk_sys)
        if (sys_reset_q === 1'b1) n_rst <= n_rst + 1;
    // ==========================================================
    // Shared tasks
    task finish_test;
    begin
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    end
    endtask
    // Bus write, expecting an error only at the unmapped word
    task wr(input logic [31:0] a, input logic [31:0] d);
        int n;
    begin
        n = 0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk(n < 50, 1);
        if (n >= 50) finish_test;
        chk(bresp, a == 32'hc ? RESP_SLVERR : RESP_OKAY);
    end
    endtask
    // Bus read, comparing the masked word
    task rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
    begin
        n = 0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        chk(n < 50, 1);
        if (n >= 50) finish_test;
        chk(rresp, a == 32'hc ? RESP_SLVERR : RESP_OKAY);
        chk(rdata & m, e);
    end
    endtask
    // Unlocked control write
    task ctl(input logic [31:0] d);
    begin
        wr(32'h0, 32'h1);
        wr(32'h0, d);
    end
    endtask
    // Waits for reset or interrupt and checks the elapsed ticks
    task waitev(input logic on_irq, input int ticks);
        int n, r0;
    begin
        n = 0;
        r0 = n_rst;
        while (n < ticks * 8 + 16 && (on_irq ? wdt_irq_q : n_rst != r0) !== 1'b1)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(n > ticks * 8 - 16 && n < ticks * 8 + 16, 1);
        if (n >= ticks * 8 + 16) finish_test;
    end
    endtask
    // ==========================================================
    // Scenarios
    task t_regs;
    begin
        rdc(32'h0, 32'hffffffff, {24'h0, CONTROL_RESET});
        rdc(32'h4, 32'hffffffff, 32'h0);
        rdc(32'h8, 32'hffffffff, 32'h0);
        rdc(32'hc, 32'hffffffff, 32'h0);
        wr(32'hc, 32'h1);
    end
    endtask
    task t_unlock;
    begin
        wr(32'h0, 32'h12);
        rdc(32'h0, 32'hff, 32'h10);
        wr(32'h0, 32'h1);
        rdc(32'h0, 32'hff, 32'h11);
        wr(32'h8, 32'h1);
        wr(32'h0, 32'h12);
        rdc(32'h0, 32'hff, 32'h10);
    end
    endtask
    task t_reset_mode;
    begin
        ctl(32'h12);
        waitev(1'b0, 1024);
        rdc(32'h0, 32'hff, 32'h14);
        rdc(32'h4, 32'hff, 32'h1);
        chk(irq_q, 1'b1);
        wr(32'h8, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk(irq_q, 1'b0);
        wr(32'h8, 32'h1);
        wr(32'h4, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk(irq_q, 1'b0);
        rdc(32'h4, 32'hff, 32'h0);
        ctl(32'h10);
        rdc(32'h0, 32'hff, 32'h10);
    end
    endtask
    task t_refresh;
        int r0;
    begin
        r0 = n_rst;
        ctl(32'h12);
        repeat (4800) @(posedge clk_sys);
        chk(n_rst, r0);
        ctl(32'h12);
        waitev(1'b0, 1024);
        ctl(32'h22);
        waitev(1'b0, 2048);
        ctl(32'h10);
    end
    endtask
    task t_irq_mode;
        int r0;
    begin
        r0 = n_rst;
        ctl(32'h1a);
        waitev(1'b1, 1024);
        rdc(32'h0, 32'h0a, 32'h0a);
        ctl(32'h1a);
        repeat (2) @(posedge clk_sys);
        chk(wdt_irq_q, 1'b0);
        waitev(1'b1, 1024);
        chk(n_rst, r0);
        ctl(32'h10);
        repeat (2) @(posedge clk_sys);
        chk(wdt_irq_q, 1'b0);
    end
    endtask
    task t_immediate;
        int r0;
    begin
        r0 = n_rst;
        ctl(32'h8a);
        repeat (4) @(posedge clk_sys);
        chk(n_rst != r0, 1);
        chk(wdt_irq_q, 1'b0);
        rdc(32'h0, 32'h04, 32'h04);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(32'h0, 32'hff, {24'h0, CONTROL_RESET});
        rdc(32'h4, 32'hff, 32'h0);
    end
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        awaddr = 32'h0;
        wdata = 32'h0;
        araddr = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        n_errors = 0;
        checked = 0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs;
        t_unlock;
        t_reset_mode;
        t_refresh;
        t_irq_mode;
        t_immediate;
        finish_test;
    end
endmodule
